// [logic/tpec_regs.svh]
// Register offsets, field positions and reset values of the timer/PWM/event counter.
`ifndef TPEC_REGS_SVH
`define TPEC_REGS_SVH

// Register indices; the byte address is four times the index.
`define TPEC_IDX_RELOAD 12'h0_0CD
`define TPEC_IDX_AUX 12'h0_0D8
`define TPEC_IDX_MODE 12'h0_0DA
`define TPEC_IDX_COUNT 12'h0_0DB
`define TPEC_IDX_STAT 12'h0_0DC

// Byte addresses on the register bus.
`define TPEC_ADDR_RELOAD (`TPEC_IDX_RELOAD * 12'h0_004)
`define TPEC_ADDR_AUX (`TPEC_IDX_AUX * 12'h0_004)
`define TPEC_ADDR_MODE (`TPEC_IDX_MODE * 12'h0_004)
`define TPEC_ADDR_COUNT (`TPEC_IDX_COUNT * 12'h0_004)
`define TPEC_ADDR_STAT (`TPEC_IDX_STAT * 12'h0_004)

// Field positions in the mode control register.
`define TPEC_MODE_PWM_BIT 0
`define TPEC_MODE_TONE_BIT 1
`define TPEC_MODE_RELOAD_BIT 2
`define TPEC_MODE_EXT_BIT 3
`define TPEC_MODE_RATE_LSB 4
`define TPEC_MODE_EN_BIT 7

// Field positions in the auxiliary clock control register.
`define TPEC_AUX_WAKE_BIT 1
`define TPEC_AUX_FAST_BIT 2
`define TPEC_AUX_FAST2_BIT 3

// Field positions in the status and interrupt control register.
`define TPEC_STAT_OVF_BIT 0
`define TPEC_STAT_IEN_BIT 1
`define TPEC_STAT_PIN_BIT 2

// Reset values.
`define TPEC_RST_BYTE 8'h00

// Overflow boundary masks for the four PWM resolutions.
`define TPEC_MASK_256 8'hFF
`define TPEC_MASK_64 8'h3F
`define TPEC_MASK_32 8'h1F
`define TPEC_MASK_16 8'h0F

// Prescaler base ratios for the two internal count clocks.
`define TPEC_DIV_CPU_BASE 9'h100
`define TPEC_DIV_OSC_BASE 9'h080

`endif

// [logic/tpec_pkg.sv]
// Types shared by the timer/PWM/event counter design.
package tpec_pkg;

  // Mode control register fields, most significant first.
  typedef struct packed {
    logic enable;
    logic [2:0] rate;
    logic ext_clk;
    logic reload_en;
    logic tone_en;
    logic pwm_en;
  } tpec_mode_t;

  // Auxiliary clock control register fields that are implemented.
  typedef struct packed {
    logic fast2;
    logic fast;
    logic wake_en;
  } tpec_aux_t;

  // Shared output pin drive: level and enable.
  typedef struct packed {
    logic level;
    logic oe;
  } tpec_pin_t;

endpackage : tpec_pkg

// [logic/tpec_timer.sv]
// Eight-bit timer with prescaler, event counting, auto-reload, PWM and tone output.
// What this block does
// - Enable bit stops or runs upward counting.
// - Three-bit prescaler divides the internal count clock.
// - Fast select picks instruction or oscillator clock.
// - External select counts pin, ignores prescaler.
// - Event mode counts each pin falling edge.
// - Wrap FF to 00 sets sticky overflow flag.
// - Event mode blocks pin interrupt flag.
// - Event mode blocks pin wake-up.
// - Active reload loads counter on overflow.
// - Outside PWM, reload only when enabled.
// - Reload writes buffered until next overflow, taken at once while stopped.
// - PWM always reloads; reload and tone bits pick boundary.
// - Boundary 256, or 256/64/32/16 in PWM on the internal clock.
// - PWM enable hands output pin to PWM.
// - Tone output toggles each overflow.
// - Wake enable raises wake-up on overflow.
// - PWM high at start, low at match.
// - Interrupt enable requests interrupt on overflow.
//
// Local design decision: the APB interface to the registers.
`include "tpec_regs.svh"

module tpec_timer
  import tpec_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Count clock strobes, one cycle each, synchronous to clock_i.
  input wire logic instruction_clock_i,
  input wire logic high_osc_clock_i,
  // Asynchronous external event input pin.
  input wire logic event_pin_i,
  // GPIO drive of the shared output pin.
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  // Shared output pin.
  output logic out_pin_o,
  output logic out_pin_oe_o,
  // Requests to the system.
  output logic irq_o,
  output logic wake_req_o,
  output logic pin_irq_o,
  output logic pin_wake_o
);

  // The counter logic and all masks are built for eight bits only.
  if (CNT_W != 8)
  begin : g_bad_width
    $error("tpec_timer supports only an eight-bit counter");
  end

  // Software visible state.
  tpec_mode_t mode; // Mode control register.
  tpec_aux_t aux; // Auxiliary clock control register.
  logic [7:0] count_value; // The running counter.
  logic [7:0] reload_hold; // First buffer that software writes.
  logic [7:0] reload_value; // Active reload value used by the PWM duty compare.
  logic overflow_flag; // Sticky overflow flag.
  logic overflow_irq_enable; // Gates the overflow flag onto irq_o.
  logic pin_irq_flag; // Sticky external pin interrupt flag.

  // Datapath state.
  logic [7:0] pre_cnt; // Prescaler divider counter.
  logic ev_s1; // First synchroniser stage of the event pin.
  logic ev_s2; // Second synchroniser stage of the event pin.
  logic ev_s3; // Delayed copy of the synchronised pin for edge detection.
  logic pwm_level; // Registered PWM waveform.
  logic tone_level; // Registered half-rate tone waveform.
  logic wake_q; // Registered wake-up pulse.
  logic pin_wake_q; // Registered pin wake pulse.

  // Combinational terms.
  logic [8:0] div_ratio; // Selected prescaler ratio.
  logic src_tick; // Selected internal source strobe.
  logic pre_tick; // Prescaler output strobe.
  logic ev_fall; // Falling edge of the synchronised event pin.
  logic count_tick; // One count step of the timer.
  logic [7:0] bmask; // Overflow boundary mask.
  logic overflow; // Counter reaches its boundary on this step.
  logic reload_now; // Counter takes the reload value on overflow.
  logic wr_acc; // APB write takes effect this edge.
  logic setup; // APB setup phase.

  // Returns the counter mask for the current overflow boundary.
  function automatic logic [7:0] boundary_mask(input tpec_mode_t m);
    logic [7:0] r;
    r = `TPEC_MASK_256;
    if (m.pwm_en && !m.ext_clk)
    begin
      unique case ({m.reload_en, m.tone_en})
        2'b00: r = `TPEC_MASK_256;
        2'b01: r = `TPEC_MASK_64;
        2'b10: r = `TPEC_MASK_32;
        2'b11: r = `TPEC_MASK_16;
      endcase
    end
    return r;
  endfunction : boundary_mask

  // Matches a bus address against one register.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
    return a == reg_addr;
  endfunction : hit

  // Bus phase decode; the slave never inserts wait states.
  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pwrite_i && pstrb_i[0];
  assign pready_o = 1'b1;

  // Clock source and prescaler ratio selection.
  always_comb
  begin
    if (aux.fast)
    begin
      src_tick = high_osc_clock_i;
      div_ratio = 9'(`TPEC_DIV_OSC_BASE >> mode.rate);
    end
    else
    begin
      src_tick = instruction_clock_i;
      div_ratio = 9'(`TPEC_DIV_CPU_BASE >> mode.rate);
    end
  end

  // The prescaler emits one strobe per div_ratio source strobes.
  assign pre_tick = src_tick && ({1'b0, pre_cnt} == div_ratio - 9'h001);

  // Prescaler counter; held clear while stopped or counting the pin.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pre_cnt <= `TPEC_RST_BYTE;
    end
    else if (!mode.enable || mode.ext_clk)
    begin
      pre_cnt <= `TPEC_RST_BYTE;
    end
    else if (pre_tick)
    begin
      pre_cnt <= `TPEC_RST_BYTE;
    end
    else if (src_tick)
    begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // Event pin synchroniser and edge delay; only ev_s2 reads ev_s1.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ev_s1 <= 1'b1;
      ev_s2 <= 1'b1;
      ev_s3 <= 1'b1;
    end
    else
    begin
      ev_s1 <= event_pin_i;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  assign ev_fall = ev_s3 && !ev_s2;

  // A count step comes from the pin in event mode, else from the prescaler.
  assign count_tick = mode.enable && (mode.ext_clk ? ev_fall : pre_tick);
  assign bmask = boundary_mask(mode);
  assign overflow = count_tick && ((count_value & bmask) == bmask);
  // PWM always reloads; otherwise the reload bit decides.
  assign reload_now = mode.pwm_en || mode.reload_en;

  // Mode control register.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode <= tpec_mode_t'(`TPEC_RST_BYTE);
    end
    else if (wr_acc && hit(paddr_i, `TPEC_ADDR_MODE))
    begin
      mode <= tpec_mode_t'(pwdata_i[7:0]);
    end
  end

  // Auxiliary clock control register.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aux <= '0;
    end
    else if (wr_acc && hit(paddr_i, `TPEC_ADDR_AUX))
    begin
      aux <= pwdata_i[`TPEC_AUX_FAST2_BIT:`TPEC_AUX_WAKE_BIT];
    end
  end

  // Reload double buffer: software fills the first stage only.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reload_hold <= `TPEC_RST_BYTE;
    end
    else if (wr_acc && hit(paddr_i, `TPEC_ADDR_RELOAD))
    begin
      reload_hold <= pwdata_i[7:0];
    end
  end

  // The active stage follows the buffer while stopped, else only at overflow.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reload_value <= `TPEC_RST_BYTE;
    end
    else if (!mode.enable || overflow)
    begin
      reload_value <= reload_hold;
    end
  end

  // Counter; a software write wins over a count step in the same cycle.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_value <= `TPEC_RST_BYTE;
    end
    else if (wr_acc && hit(paddr_i, `TPEC_ADDR_COUNT))
    begin
      count_value <= pwdata_i[7:0];
    end
    else if (overflow && reload_now)
    begin
      // The buffered value moves to the active stage and the counter at once.
      count_value <= reload_hold & bmask;
    end
    else if (overflow)
    begin
      count_value <= `TPEC_RST_BYTE;
    end
    else if (count_tick)
    begin
      count_value <= count_value + 8'h01;
    end
  end

  // Overflow flag and interrupt enable; an overflow wins over a clear.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end
    else
    begin
      if (overflow)
      begin
        overflow_flag <= 1'b1;
      end
      else if (wr_acc && hit(paddr_i, `TPEC_ADDR_STAT))
      begin
        overflow_flag <= overflow_flag && pwdata_i[`TPEC_STAT_OVF_BIT];
      end
      if (wr_acc && hit(paddr_i, `TPEC_ADDR_STAT))
      begin
        overflow_irq_enable <= pwdata_i[`TPEC_STAT_IEN_BIT];
      end
    end
  end

  // Pin interrupt flag: set by pin falling edges, forced low in event mode.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_irq_flag <= 1'b0;
    end
    else if (mode.ext_clk)
    begin
      pin_irq_flag <= 1'b0;
    end
    else if (ev_fall)
    begin
      pin_irq_flag <= 1'b1;
    end
    else if (wr_acc && hit(paddr_i, `TPEC_ADDR_STAT))
    begin
      pin_irq_flag <= pin_irq_flag && pwdata_i[`TPEC_STAT_PIN_BIT];
    end
  end

  // PWM waveform: high from overflow, low from the duty match.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwm_level <= 1'b1;
    end
    else if (!mode.enable || overflow)
    begin
      pwm_level <= 1'b1;
    end
    else if ((count_value & bmask) == (reload_value & bmask))
    begin
      pwm_level <= 1'b0;
    end
  end

  // Tone waveform toggles at every overflow, giving half the overflow rate.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tone_level <= 1'b0;
    end
    else if (overflow)
    begin
      tone_level <= !tone_level;
    end
  end

  // Wake-up pulses: timer overflow when enabled, pin edge outside event mode.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wake_q <= 1'b0;
      pin_wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= overflow && aux.wake_en;
      pin_wake_q <= ev_fall && !mode.ext_clk;
    end
  end

  // Shared pin: PWM first, then tone, else the GPIO keeps it.
  always_comb
  begin
    if (mode.pwm_en)
    begin
      out_pin_o = pwm_level;
      out_pin_oe_o = 1'b1;
    end
    else if (mode.tone_en)
    begin
      out_pin_o = tone_level;
      out_pin_oe_o = 1'b1;
    end
    else
    begin
      out_pin_o = gpio_out_i;
      out_pin_oe_o = gpio_oe_i;
    end
  end

  // Request outputs.
  assign irq_o = overflow_flag && overflow_irq_enable;
  assign wake_req_o = wake_q;
  assign pin_irq_o = pin_irq_flag;
  assign pin_wake_o = pin_wake_q;

  // Read data and error are captured in the setup phase and held for access.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end
    else if (setup)
    begin
      prdata_o <= '0;
      pslverr_o <= 1'b0;
      if (hit(paddr_i, `TPEC_ADDR_MODE))
      begin
        prdata_o[7:0] <= mode;
      end
      else if (hit(paddr_i, `TPEC_ADDR_AUX))
      begin
        prdata_o[`TPEC_AUX_FAST2_BIT:`TPEC_AUX_WAKE_BIT] <= aux;
      end
      else if (hit(paddr_i, `TPEC_ADDR_COUNT))
      begin
        prdata_o[7:0] <= count_value;
      end
      else if (hit(paddr_i, `TPEC_ADDR_STAT))
      begin
        prdata_o[`TPEC_STAT_OVF_BIT] <= overflow_flag;
        prdata_o[`TPEC_STAT_IEN_BIT] <= overflow_irq_enable;
        prdata_o[`TPEC_STAT_PIN_BIT] <= pin_irq_flag;
      end
      else if (!hit(paddr_i, `TPEC_ADDR_RELOAD))
      begin
        // Unmapped address: error, reads zero, writes are dropped.
        pslverr_o <= 1'b1;
      end
    end
  end

endmodule : tpec_timer

// [verif/tpec_timer_sva.sv]
// Port-level assertions for the timer block, bound to its top module.
`include "tpec_regs.svh"

module tpec_timer_sva
  import tpec_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  input wire logic out_pin_o,
  input wire logic out_pin_oe_o,
  input wire logic irq_o,
  input wire logic wake_req_o,
  input wire logic pin_irq_o,
  input wire logic pin_wake_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // Shadow copies of the control bits, taken from completed bus writes.
  tpec_mode_t mode;
  logic wake;
  logic ien;
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i && pstrb_i[0];
  wire mapped = paddr_i == `TPEC_ADDR_RELOAD || paddr_i == `TPEC_ADDR_AUX
    || paddr_i == `TPEC_ADDR_MODE || paddr_i == `TPEC_ADDR_COUNT
    || paddr_i == `TPEC_ADDR_STAT;

  // The shadows follow each write at the edge where it takes effect.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode <= '0;
      wake <= 1'b0;
      ien <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr_i == `TPEC_ADDR_MODE) mode <= tpec_mode_t'(pwdata_i[7:0]);
      if (paddr_i == `TPEC_ADDR_AUX) wake <= pwdata_i[1];
      if (paddr_i == `TPEC_ADDR_STAT) ien <= pwdata_i[1];
    end
  end

  property p_rdy;
    acc |-> pready_o;
  endproperty
  property p_err;
    acc |-> pslverr_o == !mapped;
  endproperty
  property p_gpio;
    !mode.pwm_en && !mode.tone_en |-> out_pin_o == gpio_out_i && out_pin_oe_o == gpio_oe_i;
  endproperty
  property p_oe;
    mode.pwm_en || mode.tone_en |-> out_pin_oe_o;
  endproperty
  property p_pirq;
    mode.ext_clk && $past(mode.ext_clk) |-> !pin_irq_o;
  endproperty
  property p_pwake;
    mode.ext_clk && $past(mode.ext_clk, 3) |-> !pin_wake_o;
  endproperty
  property p_wake;
    !wake && !$past(wake) |-> !wake_req_o;
  endproperty
  property p_irq;
    irq_o |-> ien;
  endproperty

  a_rdy: assert property (p_rdy) else $error("access without ready");
  a_err: assert property (p_err) else $error("error response wrong");
  a_gpio: assert property (p_gpio) else $error("pin not under gpio");
  a_oe: assert property (p_oe) else $error("pin not driven");
  a_pirq: assert property (p_pirq) else $error("pin flag in event mode");
  a_pwake: assert property (p_pwake) else $error("pin wake in event mode");
  a_wake: assert property (p_wake) else $error("wake while disabled");
  a_irq: assert property (p_irq) else $error("irq while masked");

  c_wake: cover property (wake_req_o);
  c_irq: cover property (irq_o);
  c_evt: cover property (mode.ext_clk && acc);
endmodule : tpec_timer_sva

bind tpec_timer tpec_timer_sva u_tpec_timer_sva (.clock_i, .rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .pslverr_o, .gpio_out_i, .gpio_oe_i,
  .out_pin_o, .out_pin_oe_o, .irq_o, .wake_req_o, .pin_irq_o, .pin_wake_o);

// [verif/tpec_event_src.sv]
// Pulse source that stands in for the external event signal.
module tpec_event_src (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  output logic event_pin_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left; // Pulses still to send.
  logic [2:0] ph; // Phase within one pulse.

  // Each pulse is four cycles low then four high; the idle line rests high.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      left <= 8'h00;
      ph <= 3'h0;
    end
    else if (go_i && left == 8'h00)
    begin
      left <= n_i;
      ph <= 3'h0;
    end
    else if (left != 8'h00)
    begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) left <= left - 8'h01;
    end
  end
  assign event_pin_o = !(left != 8'h00 && ph < 3'h4);
  assign busy_o = left != 8'h00;
endmodule : tpec_event_src

// [verif/timer0_pwm_event_counter_tb.sv]
// Self-checking bench for the timer block.
`include "tpec_regs.svh"

module timer0_pwm_event_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_RLD = `TPEC_ADDR_RELOAD;
  localparam logic [11:0] A_AUX = `TPEC_ADDR_AUX;
  localparam logic [11:0] A_MOD = `TPEC_ADDR_MODE;
  localparam logic [11:0] A_CNT = `TPEC_ADDR_COUNT;
  localparam logic [11:0] A_STA = `TPEC_ADDR_STAT;
  logic clock, rst, psel, penable, pwrite, icl, gout, goe, go, ev, busy, err;
  logic pready, pslverr, opin, ooe, irq, wake, pirq, pwk, v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] n;
  logic [1:0] dv;
  int errors, n_tests, i, c, e;

  tpec_timer u_tpec_timer (.clock_i(clock), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h1), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .instruction_clock_i(icl), .high_osc_clock_i(1'b1),
    .event_pin_i(ev), .gpio_out_i(gout), .gpio_oe_i(goe), .out_pin_o(opin), .out_pin_oe_o(ooe),
    .irq_o(irq), .wake_req_o(wake), .pin_irq_o(pirq), .pin_wake_o(pwk));
  tpec_event_src u_tpec_event_src (.clock_i(clock), .rst_i(rst), .go_i(go), .n_i(n),
    .event_pin_o(ev), .busy_o(busy));

  // Clock, and an instruction strobe at a quarter of the oscillator rate.
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    dv <= dv + 2'h1;
    icl <= dv == 2'h3;
  end

  // Prints the counts and the verdict, then ends the run.
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // Compares one value and reports a mismatch.
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  // A bound that runs out counts a mismatch and ends the run.
  task bound(input int k, input int lim);
    if (k >= lim)
    begin
      errors++;
      close_out;
    end
  endtask : bound

  // One bus transfer; read data and error are kept in q and err.
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    bound(k, 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task rd_chk(input logic [11:0] a, input logic [7:0] x);
    xfer(1'b0, a, 8'h00);
    chk(q, {24'h00_0000, x});
  endtask : rd_chk

  // Polls the status register until the overflow flag shows.
  task wait_ovf;
    c = 0;
    do
    begin
      xfer(1'b0, A_STA, 8'h00);
      c++;
    end
    while (q[0] !== 1'b1 && c < 600);
    bound(c, 600);
  endtask : wait_ovf

  task wait_cyc(input int k);
    repeat (k) @(posedge clock);
  endtask : wait_cyc

  // Cuts a hung run short.
  initial
  begin
    #2_000_000;
    errors++;
    close_out;
  end

  // Main sequence.
  initial
  begin
    // Reset is asserted from time zero; every other driven input starts low, the event pin rests high.
    {rst, psel, penable, pwrite, gout, goe, go, icl} = 8'h80;
    dv = 2'h0;
    {paddr, pwdata, n} = '0;
    errors = 0;
    n_tests = 0;
    wait_cyc(3);
    rst <= 1'b0;
    rd_chk(A_RLD, 8'h00);
    rd_chk(A_AUX, 8'h00);
    rd_chk(A_MOD, 8'h00);
    rd_chk(A_CNT, 8'h00);
    rd_chk(A_STA, 8'h00);
    rd_chk(12'h000, 8'h00);
    chk(err, 1'b1);
    $display("test reset done");
    for (i = 0; i < 13; i++)
    begin
      xfer(1'b1, A_AUX, (i > 7) ? 8'h04 : 8'h00);
      xfer(1'b1, A_CNT, 8'h00);
      xfer(1'b1, A_MOD, 8'(8'h80 | ((i % 8) << 4)));
      wait_cyc(1024);
      xfer(1'b1, A_MOD, 8'h00);
      xfer(1'b0, A_CNT, 8'h00);
      e = (i > 7) ? (8 << (i - 8)) : (1 << i);
      chk(q >= e - 1 && q <= e + 1, 1'b1);
    end
    $display("test rates done");
    xfer(1'b1, A_AUX, 8'h00);
    xfer(1'b1, A_STA, 8'h02);
    xfer(1'b1, A_CNT, 8'hFF);
    xfer(1'b1, A_RLD, 8'hFF);
    xfer(1'b1, A_MOD, 8'h84);
    wait_ovf;
    chk(irq, 1'b1);
    rd_chk(A_CNT, 8'hFF);
    xfer(1'b1, A_RLD, 8'h40);
    rd_chk(A_CNT, 8'hFF);
    xfer(1'b1, A_STA, 8'h02);
    rd_chk(A_STA, 8'h02);
    chk(irq, 1'b0);
    xfer(1'b1, A_MOD, 8'h04);
    xfer(1'b0, A_CNT, 8'h00);
    e = q;
    wait_cyc(1100);
    rd_chk(A_CNT, 8'(e));
    xfer(1'b1, A_RLD, 8'hFF);
    xfer(1'b1, A_CNT, 8'hFF);
    xfer(1'b1, A_STA, 8'h00);
    xfer(1'b1, A_MOD, 8'h80);
    wait_ovf;
    rd_chk(A_CNT, 8'h00);
    $display("test reload done");
    xfer(1'b1, A_MOD, 8'h00);
    xfer(1'b1, A_AUX, 8'h04);
    xfer(1'b1, A_STA, 8'h00);
    xfer(1'b1, A_CNT, 8'hFE);
    xfer(1'b1, A_RLD, 8'hFE);
    xfer(1'b1, A_MOD, 8'hFC);
    wait_cyc(300);
    rd_chk(A_CNT, 8'hFE);
    n <= 8'h03;
    go <= 1'b1;
    wait_cyc(1);
    go <= 1'b0;
    c = 0;
    e = 0;
    // Outputs are sampled on the falling edge, where they have settled.
    do
    begin
      @(negedge clock);
      c++;
      e += (pwk !== 1'b0);
    end
    while (busy !== 1'b0 && c < 100);
    bound(c, 100);
    wait_cyc(5);
    rd_chk(A_CNT, 8'hFF);
    rd_chk(A_STA, 8'h01);
    chk(pirq, 1'b0);
    chk(e, 0);
    $display("test event done");
    xfer(1'b1, A_MOD, 8'h00);
    xfer(1'b1, A_AUX, 8'h00);
    xfer(1'b1, A_CNT, 8'hFF);
    xfer(1'b1, A_RLD, 8'hFF);
    xfer(1'b1, A_MOD, 8'hF6);
    c = 0;
    // The pin level is sampled on falling edges, away from its launching edge.
    @(negedge clock);
    v = opin;
    repeat (80)
    begin
      @(negedge clock);
      c += (opin !== v);
      v = opin;
    end
    chk(ooe, 1'b1);
    chk(c >= 9 && c <= 11, 1'b1);
    xfer(1'b1, A_MOD, 8'h00);
    xfer(1'b1, A_CNT, 8'h00);
    xfer(1'b1, A_RLD, 8'h00);
    xfer(1'b1, A_STA, 8'h00);
    xfer(1'b1, A_MOD, 8'hF7);
    repeat (8)
    begin
      wait_cyc(20);
      xfer(1'b0, A_CNT, 8'h00);
      chk(q & 32'h0000_00F0, 32'h0000_0000);
    end
    chk(ooe, 1'b1);
    rd_chk(A_STA, 8'h01);
    xfer(1'b1, A_MOD, 8'h00);
    gout <= 1'b0;
    goe <= 1'b1;
    wait_cyc(2);
    chk({opin, ooe}, 2'h1);
    $display("test outputs done");
    xfer(1'b1, A_AUX, 8'h02);
    xfer(1'b1, A_CNT, 8'hFF);
    xfer(1'b1, A_RLD, 8'hFF);
    xfer(1'b1, A_MOD, 8'hF4);
    c = 0;
    do
    begin
      @(negedge clock);
      c++;
    end
    while (wake !== 1'b1 && c < 40);
    chk(wake, 1'b1);
    xfer(1'b1, A_AUX, 8'h00);
    // One edge may still carry a pulse decided before the enable fell.
    wait_cyc(1);
    c = 0;
    repeat (40)
    begin
      @(negedge clock);
      c += (wake !== 1'b0);
    end
    chk(c, 0);
    $display("test wake done");
    close_out;
  end
endmodule : timer0_pwm_event_counter_tb
